// ===== pkg/cgcc_pkg.sv
// Constants and register map of the channel gain and chop configuration bank
`default_nettype none
package cgcc_pkg;

	// ----------------------------------------------------------------
	// Bus and field widths
	// ----------------------------------------------------------------
	localparam int CGCC_DATA_W = 32;
	localparam int CGCC_ADR_W = 8;
	localparam int CGCC_REG_W = 16;
	localparam int CGCC_SEL_W = 4;
	localparam int CGCC_GAIN_W = 3;
	localparam int CGCC_GAIN_FACTOR_W = 8;
	localparam int CGCC_DELAY_CODE_W = 4;
	localparam int CGCC_DELAY_CYC_W = 13;
	localparam int CGCC_COUNT_W = 3;
	localparam int CGCC_LEN_W = 3;

	// ----------------------------------------------------------------
	// Register indices and byte addresses (index times four)
	// ----------------------------------------------------------------
	localparam logic [5:0] CGCC_IDX_LOWER_GAINS = 6'h04;
	localparam logic [5:0] CGCC_IDX_UPPER_GAINS = 6'h05;
	localparam logic [5:0] CGCC_IDX_CONFIG = 6'h06;
	localparam logic [5:0] CGCC_IDX_SETTLE_STATUS = 6'h07;
	localparam logic [7:0] CGCC_ADR_LOWER_GAINS = {CGCC_IDX_LOWER_GAINS, 2'h0};
	localparam logic [7:0] CGCC_ADR_UPPER_GAINS = {CGCC_IDX_UPPER_GAINS, 2'h0};
	localparam logic [7:0] CGCC_ADR_CONFIG = {CGCC_IDX_CONFIG, 2'h0};
	localparam logic [7:0] CGCC_ADR_SETTLE_STATUS = {CGCC_IDX_SETTLE_STATUS, 2'h0};

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [15:0] CGCC_RST_LOWER_GAINS = 16'h0000;
	localparam logic [15:0] CGCC_RST_UPPER_GAINS = 16'h0000;
	localparam logic [15:0] CGCC_RST_CONFIG = 16'h0600;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CGCC_GAIN_SLOT0_LSB = 0;
	localparam int CGCC_GAIN_SLOT1_LSB = 4;
	localparam int CGCC_GAIN_SLOT2_LSB = 8;
	localparam int CGCC_GAIN_SLOT3_LSB = 12;
	localparam int CGCC_CFG_DELAY_LSB = 9;
	localparam int CGCC_CFG_CHOP_EN_BIT = 8;
	localparam int CGCC_CFG_ALL_CH_BIT = 7;
	localparam int CGCC_CFG_COUNT_LSB = 4;
	localparam int CGCC_CFG_LEN_LSB = 1;
	localparam int CGCC_CFG_DETECT_EN_BIT = 0;

	// ----------------------------------------------------------------
	// Decode of power-of-two codes
	// ----------------------------------------------------------------
	localparam int CGCC_GAIN_BASE_SHIFT = 0;
	localparam int CGCC_GAIN_MAX_CODE = 7;
	localparam int CGCC_DELAY_BASE_SHIFT = 1;
	localparam int CGCC_DELAY_MAX_CODE = 11;
	localparam int CGCC_GAIN_RST_CODE = 0;
	localparam int CGCC_DELAY_RST_CODE = 3;

endpackage
`default_nettype wire

// ===== verilog/cgcc_pow2_decode.sv
// Registered decoder from a code to a power-of-two value
`timescale 1ns/1ps
`default_nettype none
module cgcc_pow2_decode #(
	parameter int CODE_W = 3,
	parameter int OUT_W = 8,
	parameter int BASE_SHIFT = 0,
	parameter int MAX_CODE = 7,
	parameter int RESET_CODE = 0
) (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic [CODE_W-1:0] code,
	output logic [OUT_W-1:0] factor
);

	localparam logic [OUT_W-1:0] RESET_FACTOR = {{(OUT_W-1){1'b0}}, 1'b1} << (RESET_CODE + BASE_SHIFT);

	logic [OUT_W-1:0] next_factor;
	int eff;

	// Codes past the top step saturate, so no code yields a zero value
	always_comb begin
		eff = int'(code);
		if (eff > MAX_CODE) begin
			eff = MAX_CODE;
		end
		for (int i = 0; i < OUT_W; i++) begin
			next_factor[i] = (i == eff + BASE_SHIFT);
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			factor <= RESET_FACTOR;
		end else begin
			factor <= next_factor;
		end
	end

endmodule
`default_nettype wire

// ===== verilog/cgcc_regs.sv
// Gain and chop configuration register bank with classic Wishbone slave
//
// Summary of operation
// - Lower gains bits 2:0 drive channel 0 gain
// - Upper gains bits 14:12 drive channel 7 gain
// - Upper gains bits 10:8 drive channel 6 gain
// - Upper gains bits 6:4 drive channel 5 gain
// - Upper gains bits 2:0 drive channel 4 gain
// - Upper gains at index 5, reset 0000h
// - Config at index 6, reset 0600h
// - Config bits 12:9 select settle delay count
// - Lower gains at index 4, reset 0000h
`timescale 1ns/1ps
`default_nettype none
module cgcc_regs
	import cgcc_pkg::*;
(
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [CGCC_ADR_W-1:0] wb_adr_i,
	input wire logic [CGCC_SEL_W-1:0] wb_sel_i,
	input wire logic [CGCC_DATA_W-1:0] wb_dat_i,
	output logic [CGCC_DATA_W-1:0] wb_dat_o,
	output logic wb_ack_o,
	output logic [CGCC_GAIN_W-1:0] ch0_gain_code,
	output logic [CGCC_GAIN_W-1:0] ch1_gain_code,
	output logic [CGCC_GAIN_W-1:0] ch2_gain_code,
	output logic [CGCC_GAIN_W-1:0] ch3_gain_code,
	output logic [CGCC_GAIN_W-1:0] ch4_gain_code,
	output logic [CGCC_GAIN_W-1:0] ch5_gain_code,
	output logic [CGCC_GAIN_W-1:0] ch6_gain_code,
	output logic [CGCC_GAIN_W-1:0] ch7_gain_code,
	output logic [CGCC_GAIN_FACTOR_W-1:0] ch0_gain_factor,
	output logic [CGCC_GAIN_FACTOR_W-1:0] ch1_gain_factor,
	output logic [CGCC_GAIN_FACTOR_W-1:0] ch2_gain_factor,
	output logic [CGCC_GAIN_FACTOR_W-1:0] ch3_gain_factor,
	output logic [CGCC_GAIN_FACTOR_W-1:0] ch4_gain_factor,
	output logic [CGCC_GAIN_FACTOR_W-1:0] ch5_gain_factor,
	output logic [CGCC_GAIN_FACTOR_W-1:0] ch6_gain_factor,
	output logic [CGCC_GAIN_FACTOR_W-1:0] ch7_gain_factor,
	output logic [CGCC_DELAY_CODE_W-1:0] chop_settle_delay,
	output logic [CGCC_DELAY_CYC_W-1:0] chop_settle_cycles,
	output logic chop_enable,
	output logic detect_all_channels,
	output logic [CGCC_COUNT_W-1:0] detect_count,
	output logic [CGCC_LEN_W-1:0] detect_length,
	output logic detect_enable
);

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	logic [CGCC_REG_W-1:0] lower_channel_gains;
	logic [CGCC_REG_W-1:0] upper_channel_gains;
	logic [CGCC_REG_W-1:0] chop_and_detect_config;
	logic [CGCC_REG_W-1:0] next_lower;
	logic [CGCC_REG_W-1:0] next_upper;
	logic [CGCC_REG_W-1:0] next_config;
	logic [CGCC_REG_W-1:0] lane_mask;
	logic [CGCC_DATA_W-1:0] next_rdata;
	logic [CGCC_GAIN_FACTOR_W-1:0] gain_factor [8];
	logic [CGCC_GAIN_W-1:0] gain_code [8];
	logic req;
	logic take;
	logic wr_lower;
	logic wr_upper;
	logic wr_config;

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	// One wait state; the !ack term keeps a held request from writing twice
	assign req = wb_cyc_i && wb_stb_i;
	assign take = req && !wb_ack_o;
	assign wr_lower = take && wb_we_i && (wb_adr_i == CGCC_ADR_LOWER_GAINS);
	assign wr_upper = take && wb_we_i && (wb_adr_i == CGCC_ADR_UPPER_GAINS);
	assign wr_config = take && wb_we_i && (wb_adr_i == CGCC_ADR_CONFIG);
	// Only the two low byte lanes hold storage
	assign lane_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

	always_comb begin
		next_lower = (lower_channel_gains & ~lane_mask) | (wb_dat_i[15:0] & lane_mask);
		next_upper = (upper_channel_gains & ~lane_mask) | (wb_dat_i[15:0] & lane_mask);
		next_config = (chop_and_detect_config & ~lane_mask) | (wb_dat_i[15:0] & lane_mask);
	end

	always_comb begin
		next_rdata = '0;
		unique case (wb_adr_i)
			CGCC_ADR_LOWER_GAINS: begin
				next_rdata = {16'h0000, lower_channel_gains};
			end
			CGCC_ADR_UPPER_GAINS: begin
				next_rdata = {16'h0000, upper_channel_gains};
			end
			CGCC_ADR_CONFIG: begin
				next_rdata = {16'h0000, chop_and_detect_config};
			end
			CGCC_ADR_SETTLE_STATUS: begin
				next_rdata = {19'h00000, chop_settle_cycles};
			end
			default: begin
				next_rdata = '0;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= take;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			wb_dat_o <= '0;
		end else if (take && !wb_we_i) begin
			wb_dat_o <= next_rdata;
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	// Reserved bits are stored as written; software is trusted to keep them zero
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			lower_channel_gains <= CGCC_RST_LOWER_GAINS;
		end else if (wr_lower) begin
			lower_channel_gains <= next_lower;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			upper_channel_gains <= CGCC_RST_UPPER_GAINS;
		end else if (wr_upper) begin
			upper_channel_gains <= next_upper;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			chop_and_detect_config <= CGCC_RST_CONFIG;
		end else if (wr_config) begin
			chop_and_detect_config <= next_config;
		end
	end

	// ----------------------------------------------------------------
	// Field outputs
	// ----------------------------------------------------------------
	assign ch0_gain_code = lower_channel_gains[CGCC_GAIN_SLOT0_LSB +: CGCC_GAIN_W];
	assign ch1_gain_code = lower_channel_gains[CGCC_GAIN_SLOT1_LSB +: CGCC_GAIN_W];
	assign ch2_gain_code = lower_channel_gains[CGCC_GAIN_SLOT2_LSB +: CGCC_GAIN_W];
	assign ch3_gain_code = lower_channel_gains[CGCC_GAIN_SLOT3_LSB +: CGCC_GAIN_W];
	assign ch4_gain_code = upper_channel_gains[CGCC_GAIN_SLOT0_LSB +: CGCC_GAIN_W];
	assign ch5_gain_code = upper_channel_gains[CGCC_GAIN_SLOT1_LSB +: CGCC_GAIN_W];
	assign ch6_gain_code = upper_channel_gains[CGCC_GAIN_SLOT2_LSB +: CGCC_GAIN_W];
	assign ch7_gain_code = upper_channel_gains[CGCC_GAIN_SLOT3_LSB +: CGCC_GAIN_W];

	assign chop_settle_delay = chop_and_detect_config[CGCC_CFG_DELAY_LSB +: CGCC_DELAY_CODE_W];
	assign chop_enable = chop_and_detect_config[CGCC_CFG_CHOP_EN_BIT];
	assign detect_all_channels = chop_and_detect_config[CGCC_CFG_ALL_CH_BIT];
	assign detect_count = chop_and_detect_config[CGCC_CFG_COUNT_LSB +: CGCC_COUNT_W];
	assign detect_length = chop_and_detect_config[CGCC_CFG_LEN_LSB +: CGCC_LEN_W];
	assign detect_enable = chop_and_detect_config[CGCC_CFG_DETECT_EN_BIT];

	// ----------------------------------------------------------------
	// Decoders
	// ----------------------------------------------------------------
	assign gain_code[0] = ch0_gain_code;
	assign gain_code[1] = ch1_gain_code;
	assign gain_code[2] = ch2_gain_code;
	assign gain_code[3] = ch3_gain_code;
	assign gain_code[4] = ch4_gain_code;
	assign gain_code[5] = ch5_gain_code;
	assign gain_code[6] = ch6_gain_code;
	assign gain_code[7] = ch7_gain_code;

	for (genvar g = 0; g < 8; g++) begin : gen_gain
		cgcc_pow2_decode #(
			.CODE_W(CGCC_GAIN_W),
			.OUT_W(CGCC_GAIN_FACTOR_W),
			.BASE_SHIFT(CGCC_GAIN_BASE_SHIFT),
			.MAX_CODE(CGCC_GAIN_MAX_CODE),
			.RESET_CODE(CGCC_GAIN_RST_CODE)
		) cgcc_pow2_decode_i (
			.sys_clk(sys_clk),
			.arst_n(arst_n),
			.code(gain_code[g]),
			.factor(gain_factor[g])
		);
	end

	assign ch0_gain_factor = gain_factor[0];
	assign ch1_gain_factor = gain_factor[1];
	assign ch2_gain_factor = gain_factor[2];
	assign ch3_gain_factor = gain_factor[3];
	assign ch4_gain_factor = gain_factor[4];
	assign ch5_gain_factor = gain_factor[5];
	assign ch6_gain_factor = gain_factor[6];
	assign ch7_gain_factor = gain_factor[7];

	// Codes above the 4096 step saturate rather than wrap to a short delay
	cgcc_pow2_decode #(
		.CODE_W(CGCC_DELAY_CODE_W),
		.OUT_W(CGCC_DELAY_CYC_W),
		.BASE_SHIFT(CGCC_DELAY_BASE_SHIFT),
		.MAX_CODE(CGCC_DELAY_MAX_CODE),
		.RESET_CODE(CGCC_DELAY_RST_CODE)
	) cgcc_pow2_decode_i (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.code(chop_settle_delay),
		.factor(chop_settle_cycles)
	);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	logic cfg_written;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			cfg_written <= 1'b0;
		end else if (wr_config) begin
			cfg_written <= 1'b1;
		end
	end

	a_ack_single_pulse: assert property (@(posedge sys_clk) disable iff (!arst_n)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");

	a_ack_after_req: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(req && !wb_ack_o) |=> wb_ack_o)
		else $error("request not answered in one cycle");

	a_ch0_gain_write: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(wr_lower && wb_sel_i[0]) |=> (ch0_gain_code == $past(wb_dat_i[2:0])))
		else $error("channel 0 gain not written");

	a_ch7_gain_write: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(wr_upper && wb_sel_i[1]) |=> (ch7_gain_code == $past(wb_dat_i[14:12])))
		else $error("channel 7 gain not written");

	a_ch6_gain_write: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(wr_upper && wb_sel_i[1]) |=> (ch6_gain_code == $past(wb_dat_i[10:8])))
		else $error("channel 6 gain not written");

	a_ch5_gain_write: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(wr_upper && wb_sel_i[0]) |=> (ch5_gain_code == $past(wb_dat_i[6:4])))
		else $error("channel 5 gain not written");

	a_ch4_gain_hold: assert property (@(posedge sys_clk) disable iff (!arst_n)
		!(wr_upper && wb_sel_i[0]) |=> $stable(ch4_gain_code))
		else $error("channel 4 gain changed without write");

	a_gain_decoded: assert property (@(posedge sys_clk) disable iff (!arst_n)
		$stable(ch6_gain_code) |=> (ch6_gain_factor == (8'h01 << $past(ch6_gain_code))))
		else $error("channel 6 gain factor wrong");

	a_upper_readback: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(take && !wb_we_i && wb_adr_i == CGCC_ADR_UPPER_GAINS)
		|=> (wb_ack_o && wb_dat_o == {16'h0000, $past(upper_channel_gains)}))
		else $error("upper gains readback wrong");

	a_lower_readback: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(take && !wb_we_i && wb_adr_i == CGCC_ADR_LOWER_GAINS)
		|=> (wb_dat_o == {16'h0000, $past(lower_channel_gains)}))
		else $error("lower gains readback wrong");

	a_config_reset: assert property (@(posedge sys_clk) disable iff (!arst_n)
		!cfg_written |-> (chop_and_detect_config == CGCC_RST_CONFIG
		&& chop_settle_delay == CGCC_DELAY_CODE_W'(CGCC_DELAY_RST_CODE)))
		else $error("config left its reset value");

	a_settle_decode: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(chop_settle_delay <= 4'hB) |=> (chop_settle_cycles == (13'h0002 << $past(chop_settle_delay))))
		else $error("settle delay count wrong");

	a_detect_forward: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(wr_config && wb_sel_i[0] && wb_sel_i[1]) |=> (chop_enable == $past(wb_dat_i[8])
		&& detect_enable == $past(wb_dat_i[0]) && detect_count == $past(wb_dat_i[6:4])))
		else $error("chop or detect field not forwarded");

	a_unmapped_zero: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(take && !wb_we_i && wb_adr_i != CGCC_ADR_LOWER_GAINS && wb_adr_i != CGCC_ADR_UPPER_GAINS
		&& wb_adr_i != CGCC_ADR_CONFIG && wb_adr_i != CGCC_ADR_SETTLE_STATUS) |=> (wb_dat_o == '0))
		else $error("unmapped read not zero");

endmodule
`default_nettype wire

// ===== dv/cgcc_regs_test.sv
// Self-checking testbench for the gain and chop configuration register bank
`timescale 1ns/1ps
`default_nettype none
module cgcc_regs_test
	import cgcc_pkg::*;
;
	// ------------------------------------------------------------
	// Signals and design instance
	// ------------------------------------------------------------
	logic sys_clk, arst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [CGCC_ADR_W-1:0] wb_adr_i;
	logic [CGCC_SEL_W-1:0] wb_sel_i;
	logic [CGCC_DATA_W-1:0] wb_dat_i, wb_dat_o;
	logic [CGCC_GAIN_W-1:0] code_a [8];
	logic [CGCC_GAIN_FACTOR_W-1:0] fac_a [8];
	logic [CGCC_DELAY_CODE_W-1:0] chop_settle_delay;
	logic [CGCC_DELAY_CYC_W-1:0] chop_settle_cycles;
	logic chop_enable, detect_all_channels, detect_enable;
	logic [CGCC_COUNT_W-1:0] detect_count;
	logic [CGCC_LEN_W-1:0] detect_length;
	int fails, n_checks;
	cgcc_regs cgcc_regs_i (.sys_clk(sys_clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.ch0_gain_code(code_a[0]), .ch1_gain_code(code_a[1]), .ch2_gain_code(code_a[2]),
		.ch3_gain_code(code_a[3]), .ch4_gain_code(code_a[4]), .ch5_gain_code(code_a[5]),
		.ch6_gain_code(code_a[6]), .ch7_gain_code(code_a[7]),
		.ch0_gain_factor(fac_a[0]), .ch1_gain_factor(fac_a[1]), .ch2_gain_factor(fac_a[2]),
		.ch3_gain_factor(fac_a[3]), .ch4_gain_factor(fac_a[4]), .ch5_gain_factor(fac_a[5]),
		.ch6_gain_factor(fac_a[6]), .ch7_gain_factor(fac_a[7]),
		.chop_settle_delay(chop_settle_delay), .chop_settle_cycles(chop_settle_cycles),
		.chop_enable(chop_enable), .detect_all_channels(detect_all_channels),
		.detect_count(detect_count), .detect_length(detect_length),
		.detect_enable(detect_enable));

	// ------------------------------------------------------------
	// Clock, comparison, closing
	// ------------------------------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test();
		$display("checks=%0d mismatches=%0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// Classic single-cycle bus master
	// ------------------------------------------------------------
	task automatic bus(input logic we, input logic [7:0] adr, input logic [3:0] sel,
		input logic [15:0] wd, output logic [31:0] rd);
		@(posedge sys_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_sel_i <= sel;
		wb_dat_i <= {16'h0000, wd};
		// No latency assumed; a missing ack is left to the watchdog
		do begin
			@(posedge sys_clk);
		end while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] adr, input logic [3:0] sel, input logic [15:0] wd);
		logic [31:0] d;
		bus(1'b1, adr, sel, wd, d);
		@(posedge sys_clk);
		#1;
	endtask
	task automatic rd_chk(input logic [7:0] adr, input logic [15:0] exp);
		logic [31:0] d;
		bus(1'b0, adr, 4'h3, 16'h0000, d);
		check(d, {16'h0000, exp});
	endtask
	// Reserved gain bits always packed as zero by the host
	function automatic logic [15:0] pack(input logic [2:0] a, b, c, e);
		return {1'b0, e, 1'b0, c, 1'b0, b, 1'b0, a};
	endfunction

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset_values();
		#1;
		for (int k = 0; k < 8; k++) begin
			check(code_a[k], 32'h0);
			check(fac_a[k], 32'h1);
		end
		check(chop_settle_delay, 32'h3);
		check(chop_settle_cycles, 32'h10);
		check({chop_enable, detect_all_channels, detect_count, detect_length, detect_enable},
			32'h0);
		rd_chk(8'h10, 16'h0000);
		rd_chk(8'h14, 16'h0000);
		rd_chk(8'h18, 16'h0600);
		$display("reset values test done");
	endtask
	// Every code in every slot, slots shifted so a swapped field shows
	task automatic t_gain_codes();
		logic [2:0] c [8];
		for (int v = 0; v < 8; v++) begin
			for (int k = 0; k < 8; k++) c[k] = 3'(v + k);
			wr(8'h10, 4'h3, pack(c[0], c[1], c[2], c[3]));
			wr(8'h14, 4'h3, pack(c[4], c[5], c[6], c[7]));
			for (int k = 0; k < 8; k++) begin
				check(code_a[k], {29'h0, c[k]});
				check(fac_a[k], 32'h1 << c[k]);
			end
			rd_chk(8'h10, pack(c[0], c[1], c[2], c[3]));
			rd_chk(8'h14, pack(c[4], c[5], c[6], c[7]));
		end
		$display("gain code test done");
	endtask
	// All documented delay codes with shifting detect fields
	task automatic t_config();
		logic [15:0] w;
		for (int d = 0; d < 12; d++) begin
			w = {3'h0, 4'(d), 1'(d), 1'(d >> 1), 3'(d), 3'(~d), 1'(~d)};
			wr(8'h18, 4'h3, w);
			check(chop_settle_delay, 32'(d));
			check(chop_settle_cycles, 32'h2 << d);
			check(chop_enable, 32'(w[8]));
			check(detect_all_channels, 32'(w[7]));
			check(detect_count, 32'(w[6:4]));
			check(detect_length, 32'(w[3:1]));
			check(detect_enable, 32'(w[0]));
			rd_chk(8'h18, w);
			rd_chk(8'h1C, 16'(32'h2 << d));
		end
		$display("config test done");
	endtask
	// Byte lanes, empty select and addresses outside the map
	task automatic t_lanes_unmapped();
		wr(8'h14, 4'h3, 16'h7777);
		wr(8'h14, 4'h1, 16'h0000);
		rd_chk(8'h14, 16'h7700);
		check(code_a[4], 32'h0);
		check(code_a[7], 32'h7);
		wr(8'h14, 4'h0, 16'h0000);
		rd_chk(8'h14, 16'h7700);
		wr(8'h20, 4'h3, 16'h1234);
		rd_chk(8'h20, 16'h0000);
		rd_chk(8'h15, 16'h0000);
		rd_chk(8'h14, 16'h7700);
		rd_chk(8'h10, pack(3'h7, 3'h0, 3'h1, 3'h2));
		$display("lane and unmapped test done");
	endtask

	// ------------------------------------------------------------
	// Main sequence and watchdog
	// ------------------------------------------------------------
	task automatic do_reset();
		arst_n <= 1'b0;
		repeat (10) @(posedge sys_clk);
		arst_n <= 1'b1;
	endtask
	initial begin
		fails = 0;
		n_checks = 0;
		arst_n = 1'b0;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'h0;
		wb_dat_i = 32'h0000_0000;
		do_reset();
		t_reset_values();
		t_gain_codes();
		t_config();
		t_lanes_unmapped();
		// Mid-run reset must restore every field
		do_reset();
		t_reset_values();
		end_of_test();
	end
	initial begin
		// Tests take well under 2000 cycles
		repeat (20000) @(posedge sys_clk);
		fails++;
		end_of_test();
	end
endmodule
`default_nettype wire
